// [design/ulep_ctl_if.sv]
/*
  Carrier between the register file and the handshake decider.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface ulep_ctl_if;
  import ulep_pkg::*;
  logic       ep0_tx_data_toggle;            // EP0 toggle
  logic       ep0_force_stall;               // EP0 stall
  logic       ep0_tx_enable;                 // EP0 transmit enable
  logic       ep0_rx_enable;                 // EP0 receive enable
  logic       ep12_tx_data_toggle;           // Shared toggle
  logic       shared_buffer_endpoint_select; // 0 EP1, 1 EP2
  logic       ep12_tx_enable;                // Shared transmit enable
  logic       auto_status_out;               // Auto status stage
  logic       endpoint_one_enable;           // EP1 enable
  logic       endpoint_two_enable;           // EP2 enable
  logic       endpoint_one_force_stall;      // EP1 stall
  logic       endpoint_two_force_stall;      // EP2 stall
  logic       ep0_tx_done_flag;              // EP0 sent
  logic       ep0_rx_done_flag;              // EP0 received
  logic       ep12_tx_done_flag;             // Shared sent
  logic       status_stage;                  // OUT ends control read
  logic       tok_valid;                     // Token pulse
  ulep_tok_t  tok_kind;                      // Token kind
  logic [1:0] tok_ep;                        // Token endpoint
  ulep_ans_t  answer;                        // Decided handshake
  modport regs (output ep0_tx_data_toggle, ep0_force_stall, ep0_tx_enable,
    ep0_rx_enable, ep12_tx_data_toggle, shared_buffer_endpoint_select,
    ep12_tx_enable, auto_status_out, endpoint_one_enable,
    endpoint_two_enable, endpoint_one_force_stall, endpoint_two_force_stall,
    ep0_tx_done_flag, ep0_rx_done_flag, ep12_tx_done_flag, status_stage,
    tok_valid, tok_kind, tok_ep, input answer);
  modport dec (input ep0_tx_data_toggle, ep0_force_stall, ep0_tx_enable,
    ep0_rx_enable, ep12_tx_data_toggle, shared_buffer_endpoint_select,
    ep12_tx_enable, auto_status_out, endpoint_one_enable,
    endpoint_two_enable, endpoint_one_force_stall, endpoint_two_force_stall,
    ep0_tx_done_flag, ep0_rx_done_flag, ep12_tx_done_flag, status_stage,
    tok_valid, tok_kind, tok_ep, output answer);
endinterface // ulep_ctl_if

// [design/ulep_decide.sv]
/*
  Combinational handshake decision for one token.
  Assumes all inputs are registered in the caller's clock domain.
*/
`timescale 1ns/1ps
module ulep_decide
  import ulep_pkg::*;
(
  ulep_ctl_if.dec c
);
  // Priority: stall, then EP0 auto status ACK, then NAK terms, then data or ACK
  always_comb begin
    c.answer = ULEP_ANS_NONE;
    if (c.tok_valid) begin
      case (c.tok_ep)
        2'd0: begin
          // [R3] [R26] EP0 stall first
          if (c.ep0_force_stall && c.tok_kind != ULEP_TOK_SETUP) begin
            c.answer = ULEP_ANS_STALL;
          end else if (c.tok_kind == ULEP_TOK_IN) begin
            // [R5] [R1] NAK or toggle-driven data PID
            if (!c.ep0_tx_enable || c.ep0_tx_done_flag) begin
              c.answer = ULEP_ANS_NAK;
            end else begin
              c.answer = c.ep0_tx_data_toggle ? ULEP_ANS_DATA1
                                              : ULEP_ANS_DATA0;
            end
          end else if (c.tok_kind == ULEP_TOK_OUT) begin
            // [R18] Auto status stage is acknowledged unless EP0 stall is set
            if (c.auto_status_out && c.status_stage) begin
              c.answer = ULEP_ANS_ACK;
            // [R7] Receive gating
            end else if (!c.ep0_rx_enable || c.ep0_rx_done_flag) begin
              c.answer = ULEP_ANS_NAK;
            end else begin
              c.answer = ULEP_ANS_ACK;
            end
          end else begin
            c.answer = ULEP_ANS_ACK;
          end
        end
        2'd1, 2'd2: begin
          // [R25] Per-endpoint stall wins
          if ((c.tok_ep == 2'd1 && c.endpoint_one_force_stall) ||
              (c.tok_ep == 2'd2 && c.endpoint_two_force_stall)) begin
            c.answer = ULEP_ANS_STALL;
          end else if (c.tok_kind != ULEP_TOK_IN) begin
            c.answer = ULEP_ANS_NONE;
          // [R13] [R24] Shared enable and done gating
          end else if (!c.ep12_tx_enable || c.ep12_tx_done_flag) begin
            c.answer = ULEP_ANS_NAK;
          // [R11] [R12] Buffer must serve this endpoint
          end else if (c.shared_buffer_endpoint_select !=
                       (c.tok_ep == 2'd2)) begin
            c.answer = ULEP_ANS_NAK;
          end else if ((c.tok_ep == 2'd1 && !c.endpoint_one_enable) ||
                       (c.tok_ep == 2'd2 && !c.endpoint_two_enable)) begin
            c.answer = ULEP_ANS_NONE;
          end else begin
            // [R10] Shared toggle picks the PID
            c.answer = c.ep12_tx_data_toggle ? ULEP_ANS_DATA1
                                             : ULEP_ANS_DATA0;
          end
        end
        default: c.answer = ULEP_ANS_NONE;
      endcase
    end
  end
endmodule // ulep_decide

// [design/ulep_pkg.sv]
/*
  Constants, register map and types for the low-speed endpoint transmit
  and handshake control block.
  Assumes a 32-bit AXI4-Lite master and a packet engine on the same clock.
*/
// Function
// [R1] EP0 IN sends DATA0/DATA1 per toggle
// [R2] Software flips toggles, hardware never does
// [R3] EP0 stall answers IN/OUT with STALL
// [R4] SETUP token clears EP0 stall
// [R5] EP0 IN NAKs when disabled or done
// [R6] Software manages EP0 transmit enable
// [R7] EP0 OUT NAKs when disabled or done
// [R8] Software manages EP0 receive enable
// [R9] Four-bit byte counts, cleared by reset
// [R10] EP1/2 IN sends DATA0/DATA1 per toggle
// [R11] Select bit routes shared buffer
// [R12] EP2 IN NAKs when buffer selects EP1
// [R13] EP1/2 IN NAKs when disabled or done
// [R14] Software sets endpoint enable with transmit
// [R15] Force resume drives K state
// [R16] Software times resume 10 to 15 ms
// [R17] Forced resume never sets resume flag
// [R18] Auto status-out answers control read OUT
// [R19] Endpoint enables bits 3 and 2
// [R20] Stall bits 1 and 0, 7:5 reserved
// [R21] Reset clears control bits
// [R22] EP0 transmit-done set after ACK
// [R23] EP0 receive-done set after ACK
// [R24] Shared transmit-done set, then NAKs
// [R25] EP1/EP2 stall takes precedence
// [R26] EP0 stall beats NAK conditions
package ulep_pkg;
  // Register numbers are not word multiples: kept as word indexes
  localparam logic [7:0] IDX_EP0_CTRL   = 8'hea;
  localparam logic [7:0] IDX_SHARED_CTRL = 8'heb;
  localparam logic [7:0] IDX_EP_EN_STALL = 8'hec;
  localparam logic [7:0] IDX_DONE_FLAGS  = 8'he8;
  // Bit positions, control endpoint, shared and enable/stall registers
  localparam int B_TOG = 7;
  localparam int B_EP0_STALL = 6;
  localparam int B_TXE = 5;
  localparam int B_RXE = 4;
  localparam int B_SEL = 6;
  localparam int B_RESUME = 4;
  localparam int B_AUTO_STAT = 4;
  localparam int B_TWO_EN = 3;
  localparam int B_ONE_EN = 2;
  localparam int B_TWO_STALL = 1;
  localparam int B_ONE_STALL = 0;
  // Done flag register positions
  localparam int B_TXD0 = 4;
  localparam int B_RXD0 = 3;
  localparam int B_TXD1 = 2;
  localparam int B_WAKE_SEEN = 0;
  localparam int CNT_W = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Handshake decision
  typedef enum logic [2:0] {
    ULEP_ANS_NONE  = 3'h0,
    ULEP_ANS_DATA0 = 3'h1,
    ULEP_ANS_DATA1 = 3'h2,
    ULEP_ANS_NAK   = 3'h3,
    ULEP_ANS_STALL = 3'h4,
    ULEP_ANS_ACK   = 3'h5
  } ulep_ans_t;

  // Token kinds from the packet engine
  typedef enum logic [1:0] {
    ULEP_TOK_IN    = 2'h0,
    ULEP_TOK_OUT   = 2'h1,
    ULEP_TOK_SETUP = 2'h2
  } ulep_tok_t;
endpackage

// [design/ulep_top.sv]
/*
  Endpoint transmit control registers with an AXI4-Lite slave, token
  handshake answer, done flags and forced resume.
  Assumes tokens and ACK events come from a packet engine on clk.
  The resume line is taken from the pins and is synchronised here.
*/
`timescale 1ns/1ps
module ulep_top
  import ulep_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Packet engine side
  input  wire logic        tok_valid,
  input  wire logic [1:0]  tok_kind,
  input  wire logic [1:0]  tok_ep,
  input  wire logic        status_stage,
  input  wire logic        host_ack,
  input  wire logic        bus_activity_pin,
  output logic [2:0]       answer,
  output logic             answer_valid,
  output logic             drive_k_state,
  output logic             resume_detected_flag
);
  ulep_ctl_if c ();                 // Control carrier
  logic [7:0] ep0_q, ep0_d;         // Control endpoint register
  logic [7:0] shr_q, shr_d;         // Shared endpoint register
  logic [7:0] ens_q, ens_d;         // Enable and stall register
  logic [4:0] flg_q, flg_d;         // Done and resume flags
  logic       aw_q, aw_d;           // Write address held
  logic       w_q, w_d;             // Write data held
  logic [11:0] awa_q, awa_d;        // Held write address
  logic [31:0] wd_q, wd_d;          // Held write data
  logic       wb_q, wb_d;           // Write strobe lane 0 held
  logic       bv_q, bv_d;           // Write response pending
  logic [1:0] br_q, br_d;           // Write response code
  logic       rv_q, rv_d;           // Read data pending
  logic [31:0] rd_q, rd_d;          // Read data
  logic [1:0] rr_q, rr_d;           // Read response
  logic [2:0] ans_q, ans_d;         // Registered answer
  logic       av_q, av_d;           // Answer pulse
  logic [1:0] last_ep_q, last_ep_d; // Endpoint owed an ACK
  logic       last_in_q, last_in_d; // Last answer was data
  logic       last_out_q, last_out_d; // Last answer accepted OUT
  logic       act_s1_q, act_s2_q;   // Activity synchroniser
  logic       act_s3_q;             // Edge history
  logic       wr_go;                // Write completes this cycle
  logic [7:0] wr_idx;               // Write word index
  logic [7:0] rd_idx;               // Read word index

  // Word index from byte address
  assign wr_idx = awa_q[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_go  = aw_q && w_q && !bv_q;

  assign c.ep0_tx_data_toggle            = ep0_q[B_TOG];
  assign c.ep0_force_stall               = ep0_q[B_EP0_STALL];
  assign c.ep0_tx_enable                 = ep0_q[B_TXE];
  assign c.ep0_rx_enable                 = ep0_q[B_RXE];
  assign c.ep12_tx_data_toggle           = shr_q[B_TOG];
  assign c.shared_buffer_endpoint_select = shr_q[B_SEL];
  assign c.ep12_tx_enable                = shr_q[B_TXE];
  assign c.auto_status_out               = ens_q[B_AUTO_STAT];
  assign c.endpoint_one_enable           = ens_q[B_ONE_EN];
  assign c.endpoint_two_enable           = ens_q[B_TWO_EN];
  assign c.endpoint_one_force_stall      = ens_q[B_ONE_STALL];
  assign c.endpoint_two_force_stall      = ens_q[B_TWO_STALL];
  assign c.ep0_tx_done_flag              = flg_q[B_TXD0];
  assign c.ep0_rx_done_flag              = flg_q[B_RXD0];
  assign c.ep12_tx_done_flag             = flg_q[B_TXD1];
  assign c.status_stage                  = status_stage;
  assign c.tok_valid                     = tok_valid;
  assign c.tok_kind                      = ulep_tok_t'(tok_kind);
  assign c.tok_ep                        = tok_ep;

  // Handshake decision
  ulep_decide u_dec (
    .c (c)
  );

  // Bus slave, registers and flags: next values
  always_comb begin
    aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; wb_d = wb_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    ep0_d = ep0_q; shr_d = shr_q; ens_d = ens_q; flg_d = flg_q;
    last_ep_d = last_ep_q; last_in_d = last_in_q; last_out_d = last_out_q;
    ans_d = 3'(c.answer);
    av_d = tok_valid && (c.answer != ULEP_ANS_NONE);
    // Channels are taken in either order
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      wb_d = s_axi_wstrb[0];
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    // Registers are 8 bits: only lane 0 matters
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = RESP_OKAY;
      case (wr_idx)
        // [R9] Byte counts writable
        IDX_EP0_CTRL:    if (wb_q) ep0_d = wd_q[7:0];
        IDX_SHARED_CTRL: if (wb_q) shr_d = wd_q[7:0];
        // [R20] Reserved bits 7:5 stay zero
        IDX_EP_EN_STALL: if (wb_q) ens_d = {3'b000, wd_q[4:0]};
        // Writing 0 clears a flag, writing 1 leaves it
        IDX_DONE_FLAGS:  if (wb_q) flg_d = flg_q & wd_q[4:0];
        default:         br_d = RESP_SLVERR;
      endcase
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      case (rd_idx)
        IDX_EP0_CTRL:    rd_d = {24'h000000, ep0_q};
        IDX_SHARED_CTRL: rd_d = {24'h000000, shr_q};
        IDX_EP_EN_STALL: rd_d = {24'h000000, ens_q};
        IDX_DONE_FLAGS:  rd_d = {27'h0000000, flg_q};
        default: begin
          rd_d = 32'h00000000;
          rr_d = RESP_SLVERR;
        end
      endcase
    end
    // [R4] SETUP clears EP0 stall, after any software write
    if (tok_valid && c.tok_kind == ULEP_TOK_SETUP) begin
      ep0_d[B_EP0_STALL] = 1'b0;
    end
    // Remember what an ACK would complete
    if (tok_valid) begin
      last_ep_d = tok_ep;
      last_in_d = (c.answer == ULEP_ANS_DATA0) ||
                  (c.answer == ULEP_ANS_DATA1);
      last_out_d = (c.answer == ULEP_ANS_ACK) &&
                   (c.tok_kind == ULEP_TOK_OUT) &&
                   !(c.auto_status_out && status_stage);
    end
    // [R23] Accepted OUT sets receive done (set wins over clear)
    if (av_q && last_out_q && last_ep_q == 2'd0) begin
      flg_d[B_RXD0] = 1'b1;
    end
    // [R22] [R24] Host ACK sets transmit done
    if (host_ack && last_in_q) begin
      if (last_ep_q == 2'd0) begin
        flg_d[B_TXD0] = 1'b1;
      end else begin
        flg_d[B_TXD1] = 1'b1;
      end
      last_in_d = 1'b0;
    end
    // [R17] Only synchronised outside activity sets the flag
    if (act_s2_q && !act_s3_q && !shr_q[B_RESUME]) begin
      flg_d[B_WAKE_SEEN] = 1'b1;
    end
    // [R2] Toggles are never flipped here
  end

  // Register stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // [R21] [R19] Control bits and counts clear
      ep0_q <= RST_BYTE; shr_q <= RST_BYTE; ens_q <= RST_BYTE;
      flg_q <= 5'h00;
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 12'h000; wd_q <= 32'h00000000;
      wb_q <= 1'b0; bv_q <= 1'b0; br_q <= RESP_OKAY; rv_q <= 1'b0;
      rd_q <= 32'h00000000; rr_q <= RESP_OKAY;
      ans_q <= 3'h0; av_q <= 1'b0;
      last_ep_q <= 2'h0; last_in_q <= 1'b0; last_out_q <= 1'b0;
      act_s1_q <= 1'b0; act_s2_q <= 1'b0; act_s3_q <= 1'b0;
    end else if (clk_en) begin
      ep0_q <= ep0_d; shr_q <= shr_d; ens_q <= ens_d; flg_q <= flg_d;
      aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d; wb_q <= wb_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
      ans_q <= ans_d; av_q <= av_d;
      last_ep_q <= last_ep_d; last_in_q <= last_in_d;
      last_out_q <= last_out_d;
      // Second stage is the only reader of the first
      act_s1_q <= bus_activity_pin;
      act_s2_q <= act_s1_q;
      act_s3_q <= act_s2_q;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign answer        = ans_q;
  assign answer_valid  = av_q;
  // [R15] Forced resume drives K while the bit stands
  assign drive_k_state = shr_q[B_RESUME];
  assign resume_detected_flag = flg_q[B_WAKE_SEEN];

  // Stall on EP0 answers IN with STALL next cycle
  ep0_stall_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && tok_valid && ep0_q[B_EP0_STALL] && tok_ep == 2'd0 &&
    tok_kind == ULEP_TOK_IN |=> ans_q == ULEP_ANS_STALL)
    else $error("ep0 stall not answered"); // [R3]
  // SETUP clears stall
  setup_clear_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && tok_valid && tok_kind == ULEP_TOK_SETUP |=> !ep0_q[B_EP0_STALL])
    else $error("setup left stall"); // [R4]
  // EP0 IN NAK
  ep0_in_nak_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && tok_valid && tok_ep == 2'd0 && tok_kind == ULEP_TOK_IN &&
    !ep0_q[B_EP0_STALL] && (!ep0_q[B_TXE] || flg_q[B_TXD0])
    |=> ans_q == ULEP_ANS_NAK) else $error("ep0 in not nak"); // [R5]
  // EP0 data PID follows toggle
  ep0_pid_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && tok_valid && tok_ep == 2'd0 && tok_kind == ULEP_TOK_IN &&
    !ep0_q[B_EP0_STALL] && ep0_q[B_TXE] && !flg_q[B_TXD0]
    |=> ans_q == (ep0_q[B_TOG] ? ULEP_ANS_DATA1 : ULEP_ANS_DATA0))
    else $error("ep0 pid wrong"); // [R1]
  // EP0 OUT NAK
  ep0_out_nak_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && tok_valid && tok_ep == 2'd0 && tok_kind == ULEP_TOK_OUT &&
    !ep0_q[B_EP0_STALL] && !(ens_q[B_AUTO_STAT] && status_stage) &&
    (!ep0_q[B_RXE] || flg_q[B_RXD0]) |=> ans_q == ULEP_ANS_NAK)
    else $error("ep0 out not nak"); // [R7]
  // EP2 with buffer on EP1 NAKs
  ep2_sel_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && tok_valid && tok_ep == 2'd2 && tok_kind == ULEP_TOK_IN &&
    !ens_q[B_TWO_STALL] && !shr_q[B_SEL] |=> ans_q == ULEP_ANS_NAK)
    else $error("ep2 select not nak"); // [R12]
  // EP1 stall wins
  ep1_stall_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && tok_valid && tok_ep == 2'd1 && ens_q[B_ONE_STALL]
    |=> ans_q == ULEP_ANS_STALL) else $error("ep1 stall lost"); // [R25]
  // Reserved bits stay zero
  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    ens_q[7:5] == 3'b000) else $error("reserved bits set"); // [R20]
  // Resume drive never raises flag by itself
  resume_flag_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && shr_q[B_RESUME] && !flg_q[B_WAKE_SEEN] |=> !flg_q[B_WAKE_SEEN])
    else $error("forced resume set flag"); // [R17]
endmodule // ulep_top

// [verif/tb_top.sv]
/*
  Self-checking bench: AXI4-Lite register tasks and token sequences.
  Assumes the host model above and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import ulep_pkg::*;
  localparam logic [11:0] A_EP0 = {2'b00, IDX_EP0_CTRL, 2'b00};
  localparam logic [11:0] A_SH  = {2'b00, IDX_SHARED_CTRL, 2'b00};
  localparam logic [11:0] A_ES  = {2'b00, IDX_EP_EN_STALL, 2'b00};
  localparam logic [11:0] A_FL  = {2'b00, IDX_DONE_FLAGS, 2'b00};
  logic        clk, reset, clk_en, pin;    // Clock, reset, pin
  logic [11:0] awaddr, araddr;             // Write and read address
  logic        awvalid, wvalid, bready;    // Write handshakes
  logic        arvalid, rready;            // Read handshakes
  logic [31:0] wdata, rdata;               // Bus data
  logic [3:0]  wstrb;                      // Byte strobes
  logic        awready, wready, bvalid;    // Slave write readies
  logic        arready, rvalid;            // Slave read readies
  logic [1:0]  bresp, rresp, kind, ep;     // Responses, token
  logic [2:0]  answer;                     // Decided handshake
  logic        tv, st, hack, av, dk, rf;   // Token link, resume
  logic [7:0]  d;                          // Read byte
  logic [1:0]  r, br;                      // Read, write response
  int          bad_count, n_tests, cyc;    // Counters

  ulep_top u_ulep_top (.clk(clk), .reset(reset), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tok_valid(tv), .tok_kind(kind), .tok_ep(ep),
    .status_stage(st), .host_ack(hack), .bus_activity_pin(pin),
    .answer(answer), .answer_valid(av), .drive_k_state(dk),
    .resume_detected_flag(rf));
  ulep_host_model u_ulep_host_model (.clk(clk), .answer(answer),
    .answer_valid(av), .tok_kind(kind), .tok_valid(tv), .tok_ep(ep),
    .status_stage(st), .host_ack(hack));

  // Free-running 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Watchdog: a hang ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_ans(input string n, input ulep_ans_t e,
                         input ulep_ans_t g);
    chk_reg(n, {5'h0, e}, {5'h0, g});
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_reg(n, {7'h0, e}, {7'h0, g});
  endtask

  // Write: both channels offered, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk_reg("reg", e, d);
    chk_reg("rresp", {6'h0, RESP_OKAY}, {6'h0, r});
  endtask

  task automatic tk(input ulep_tok_t k, input logic [1:0] e,
                    input logic s, input ulep_ans_t x);
    ulep_ans_t a;
    u_ulep_host_model.send(k, e, s, a);
    chk_ans("answer", x, a);
  endtask

  // Main sequence
  initial begin
    ulep_ans_t a;
    {bad_count, n_tests, cyc} = '0;
    {reset, clk_en, pin} = 3'b110;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rchk(A_EP0, 8'h00);
    rchk(A_SH, 8'h00);
    rchk(A_ES, 8'h00);
    rd(12'h000);
    chk_reg("slverr", {6'h0, RESP_SLVERR}, {6'h0, r}); // unmapped
    tk(ULEP_TOK_IN, 2'd0, 1'b0, ULEP_ANS_NAK);
    wr(A_EP0, 8'h2f);
    chk_reg("bresp", {6'h0, RESP_OKAY}, {6'h0, br});
    rchk(A_EP0, 8'h2f);
    tk(ULEP_TOK_IN, 2'd0, 1'b0, ULEP_ANS_DATA0);
    u_ulep_host_model.ack();
    rchk(A_FL, 8'h10);
    tk(ULEP_TOK_IN, 2'd0, 1'b0, ULEP_ANS_NAK);
    rchk(A_EP0, 8'h2f);
    wr(A_FL, 8'h00);
    wr(A_EP0, 8'hae);
    tk(ULEP_TOK_IN, 2'd0, 1'b0, ULEP_ANS_DATA1);
    wr(A_EP0, 8'he0);
    tk(ULEP_TOK_IN, 2'd0, 1'b0, ULEP_ANS_STALL);
    tk(ULEP_TOK_OUT, 2'd0, 1'b0, ULEP_ANS_STALL);
    u_ulep_host_model.send(ULEP_TOK_SETUP, 2'd0, 1'b0, a);
    rchk(A_EP0, 8'ha0);
    tk(ULEP_TOK_OUT, 2'd0, 1'b0, ULEP_ANS_NAK);
    wr(A_EP0, 8'h10);
    tk(ULEP_TOK_OUT, 2'd0, 1'b0, ULEP_ANS_ACK);
    rchk(A_FL, 8'h08);
    tk(ULEP_TOK_OUT, 2'd0, 1'b0, ULEP_ANS_NAK);
    wr(A_FL, 8'h00);
    wr(A_ES, 8'h10);
    tk(ULEP_TOK_OUT, 2'd0, 1'b1, ULEP_ANS_ACK);
    rchk(A_FL, 8'h00);
    wr(A_ES, 8'h0c);
    wr(A_SH, 8'h23);
    rchk(A_SH, 8'h23);
    tk(ULEP_TOK_IN, 2'd1, 1'b0, ULEP_ANS_DATA0);
    tk(ULEP_TOK_IN, 2'd2, 1'b0, ULEP_ANS_NAK);
    // Endpoint 1 disabled: the block stays silent
    wr(A_ES, 8'h08);
    tk(ULEP_TOK_IN, 2'd1, 1'b0, ULEP_ANS_NONE);
    wr(A_ES, 8'h0c);
    wr(A_SH, 8'he3);
    tk(ULEP_TOK_IN, 2'd2, 1'b0, ULEP_ANS_DATA1);
    u_ulep_host_model.ack();
    rchk(A_FL, 8'h04);
    tk(ULEP_TOK_IN, 2'd2, 1'b0, ULEP_ANS_NAK);
    wr(A_FL, 8'h00);
    wr(A_SH, 8'h03);
    tk(ULEP_TOK_IN, 2'd1, 1'b0, ULEP_ANS_NAK);
    wr(A_SH, 8'h23);
    wr(A_ES, 8'h0f);
    rchk(A_ES, 8'h0f);
    tk(ULEP_TOK_IN, 2'd1, 1'b0, ULEP_ANS_STALL);
    tk(ULEP_TOK_IN, 2'd2, 1'b0, ULEP_ANS_STALL);
    wr(A_SH, 8'h10);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk_bit("drive_k", 1'b1, dk);
    chk_bit("resume_flag", 1'b0, rf);
    pin <= 1'b0;
    // Wake-up held far shorter than on a real bus to keep the run short
    wr(A_SH, 8'h00);
    chk_bit("drive_k", 1'b0, dk);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk_bit("resume_flag", 1'b1, rf);
    rchk(A_FL, 8'h01);
    // Second reset in mid-run: bits set by software must clear again
    pin <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rchk(A_EP0, 8'h00);
    rchk(A_ES, 8'h00);
    results();
  end
endmodule // tb_top

// [verif/ulep_host_model.sv]
/*
  Host-side token source that faces the endpoint control block.
  Assumes answer_valid follows a taken token by exactly one cycle.
*/
`timescale 1ns/1ps
module ulep_host_model
  import ulep_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [2:0] answer,
  input  wire logic       answer_valid,
  output ulep_tok_t       tok_kind,
  output logic            tok_valid,
  output logic [1:0]      tok_ep,
  output logic            status_stage,
  output logic            host_ack
);
  // Idle link from time zero
  initial begin
    tok_valid = 1'b0;
    tok_kind = ULEP_TOK_IN;
    tok_ep = 2'h0;
    status_stage = 1'b0;
    host_ack = 1'b0;
  end

  // One token, then sample the one-cycle answer
  task automatic send(input ulep_tok_t k, input logic [1:0] e,
                      input logic st, output ulep_ans_t a);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_ep <= e;
    status_stage <= st;
    @(posedge clk);
    // Released lines show the inverse so stale values cannot pass
    tok_valid <= 1'b0;
    tok_kind <= ulep_tok_t'(~k);
    tok_ep <= ~e;
    status_stage <= ~st;
    @(posedge clk);
    a = answer_valid ? ulep_ans_t'(answer) : ULEP_ANS_NONE;
  endtask

  // Host acknowledges the data packet just sent
  task automatic ack();
    @(posedge clk);
    host_ack <= 1'b1;
    @(posedge clk);
    host_ack <= 1'b0;
  endtask
endmodule // ulep_host_model
